/* File: design/sca_pkg.sv */
package sca_pkg;

  // link byte values
  localparam logic [7:0] SCA_ADDR_WR    = 8'h5a; // device address, write
  localparam logic [7:0] SCA_ADDR_RD    = 8'h59; // device address, read
  localparam logic [7:0] SCA_MEM_HI     = 8'h00; // scratch offset high byte
  localparam logic [7:0] SCA_CMD_ACC_HI = 8'h99; // register access, first
  localparam logic [7:0] SCA_CMD_ACC_LO = 8'h37; // register access, second
  localparam logic [7:0] SCA_CMD_CPC    = 8'h87; // controller block write
  localparam logic [7:0] SCA_CMD_DONE   = 8'h00; // command completion
  localparam logic [7:0] SCA_RD_COUNT   = 8'h80; // count byte of a read
  localparam logic [7:0] SCA_IDLE_BYTE  = 8'hff; // answer when not addressed

  // scratch memory layout
  localparam int         SCA_MEM_DEPTH    = 128;
  localparam logic [6:0] SCA_OFS_DIR      = 7'h00;
  localparam logic [6:0] SCA_OFS_LEN      = 7'h01;
  localparam logic [6:0] SCA_OFS_AHI      = 7'h02;
  localparam logic [6:0] SCA_OFS_ALO      = 7'h03;
  localparam logic [6:0] SCA_OFS_DATA     = 7'h04;
  localparam logic [6:0] SCA_OFS_CPC_ADDR = 7'h02;
  localparam logic [6:0] SCA_OFS_CPC_CNT  = 7'h03;
  localparam logic [7:0] SCA_DIR_WRITE    = 8'h00;
  localparam logic [7:0] SCA_DIR_READ     = 8'h01;

  // host frame lengths before the payload
  localparam logic [7:0] SCA_LOAD_HDR = 8'h04;
  localparam logic [7:0] SCA_ACC_LEN  = 8'h04;
  localparam logic [7:0] SCA_CPC_LEN  = 8'h03;
  localparam logic [7:0] SCA_SEL_LEN  = 8'h03;

  // runtime register map
  localparam int SCA_NREG  = 35;
  localparam int SCA_NSTAT = 7;
  localparam logic [15:0] SCA_REG_ADDR [SCA_NREG] = '{
    16'h0806, 16'h0807, 16'h0808, 16'h0809, 16'h082d, 16'h082f, 16'h0831,
    16'h0833, 16'h0835, 16'h0837, 16'h0839, 16'h083b, 16'h083d, 16'h083f,
    16'h092e, 16'h0932, 16'h0936, 16'h093a, 16'h093e, 16'h3c00, 16'h3c04,
    16'h3c20, 16'h3c24, 16'h5246, 16'h525a, 16'h525b, 16'h60ca, 16'h60cc,
    16'h61c0, 16'h64ca, 16'h64cc, 16'h65c0, 16'h68ca, 16'h68cc, 16'h69c0};
  localparam logic [7:0] SCA_REG_INIT [SCA_NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfe, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h03,
    8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // status registers follow status_live instead of storing writes
  localparam logic [SCA_NREG-1:0] SCA_REG_IS_STAT = 35'h490820c00;
  localparam logic [2:0] SCA_REG_SLOT [SCA_NREG] = '{
    3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h0, 3'h2, 3'h0, 3'h0, 3'h0,
    3'h0, 3'h0, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h4, 3'h0, 3'h0, 3'h5, 3'h0, 3'h0, 3'h6};

  typedef enum logic [2:0] {
    SCA_X_IDLE = 3'b001,
    SCA_X_ACC  = 3'b010,
    SCA_X_CPC  = 3'b100
  } sca_xstate_e;

  typedef enum logic [6:0] {
    SCA_H_IDLE   = 7'b0000001,
    SCA_H_WRITE  = 7'b0000010,
    SCA_H_RSTART = 7'b0000100,
    SCA_H_RADDR  = 7'b0001000,
    SCA_H_READ   = 7'b0010000,
    SCA_H_STOP   = 7'b0100000,
    SCA_H_WAIT   = 7'b1000000
  } sca_hstate_e;

  typedef enum logic [1:0] {
    SCA_K_LOAD = 2'h0,
    SCA_K_ACC  = 2'h1,
    SCA_K_CPC  = 2'h2,
    SCA_K_READ = 2'h3
  } sca_kind_e;

endpackage

/* File: design/sca_link_if.sv */
`timescale 1ns/1ps
interface sca_link_if (
  input wire logic ref_clk // shared clock
);
  logic       start;  // frame start, one-cycle pulse
  logic       stop;   // frame stop, one-cycle pulse
  logic       wvalid; // master byte valid
  logic [7:0] wdata;  // master byte
  logic       rreq;   // master asks for one read byte
  logic       rvalid; // device read byte valid
  logic [7:0] rdata;  // device read byte
  logic       busy;   // device executing a command

  modport host (output start, stop, wvalid, wdata, rreq,
                input  rvalid, rdata, busy);
  modport dev  (input  start, stop, wvalid, wdata, rreq,
                output rvalid, rdata, busy);
endinterface

/* File: design/sca_regfile.sv */
`timescale 1ns/1ps
module sca_regfile
  import sca_pkg::*;
(
  input  wire logic                   ref_clk,     // core clock
  input  wire logic                   rst,         // sync reset
  input  wire logic                   attach,      // load initial values
  input  wire logic                   we,          // write strobe
  input  wire logic [15:0]            addr,        // register address
  input  wire logic [7:0]             wdata,       // write byte
  input  wire logic [SCA_NSTAT*8-1:0] status_live, // live status bytes
  output logic      [7:0]             rdata,       // read byte
  output logic      [SCA_NREG*8-1:0]  regs         // all register values
);

  function automatic logic [6:0] reg_find(input logic [15:0] a);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < SCA_NREG; i++) begin
      if (SCA_REG_ADDR[i] == a) begin
        r = {1'b1, 6'(i)};
      end
    end
    return r;
  endfunction

  logic [7:0] reg_q [SCA_NREG];
  wire  logic [6:0] hit_idx = reg_find(addr);
  wire  logic       hit     = hit_idx[6];
  wire  logic [5:0] idx     = hit_idx[5:0];

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < SCA_NREG; i++) begin
      if (SCA_REG_IS_STAT[i]) begin
        reg_q[i] <= status_live[SCA_REG_SLOT[i]*8 +: 8];
      end else if (rst || attach) begin
        reg_q[i] <= SCA_REG_INIT[i];
      end else if (we && hit && idx == 6'(i)) begin
        reg_q[i] <= wdata;
      end
    end
  end

  // unmapped addresses read as zero and write nowhere
  assign rdata = hit ? reg_q[idx] : 8'h00;

  always_comb begin
    regs = '0;
    for (int i = 0; i < SCA_NREG; i++) begin
      regs[i*8 +: 8] = reg_q[i];
    end
  end

endmodule // sca_regfile

/* File: design/sca_device.sv */
`timescale 1ns/1ps
// Contract
// - block write takes address, count, then bytes
// - attach loads every non-status register's initial value
// - status registers follow live conditions
// - scratch byte 0 selects write or read
// - scratch byte 1 gives the byte count
// - scratch bytes 2,3 give address, high first
// - data at offset four plus N
// - load is offset high, low, count, bytes
// - 99h 37h 00h runs the register access
// - master reads results from offset four
// - master writes offset then reads with 59h
// - read answers 80h count then memory bytes
// - stop ends a read anywhere without error
module sca_device
  import sca_pkg::*;
(
  input  wire logic                   ref_clk,      // core clock
  input  wire logic                   rst,          // sync reset
  sca_link_if.dev                     lnk,          // link to the master
  input  wire logic                   attach,       // attach command pulse
  input  wire logic [SCA_NSTAT*8-1:0] status_live,  // live status bytes
  output logic      [SCA_NREG*8-1:0]  cfg_regs,     // register values
  output logic                        cpc_wr_valid, // controller write
  output logic      [7:0]             cpc_wr_addr,  // controller register
  output logic      [7:0]             cpc_wr_data   // controller byte
);

  function automatic logic [6:0] data_ofs(input logic [7:0] n);
    return SCA_OFS_DATA + n[6:0];
  endfunction

  logic [7:0]  mem_q [SCA_MEM_DEPTH];
  logic [2:0]  pos_q;
  logic        is_wr_q;
  logic        is_rd_q;
  logic        rd_first_q;
  logic        arm_acc_q;
  logic        arm_cpc_q;
  logic [7:0]  cmd_q;
  logic [7:0]  arg_q;
  logic [7:0]  cnt_q;
  logic [6:0]  ptr_q;
  logic [7:0]  idx_q;
  sca_xstate_e xs_q;
  logic        rvalid_q;
  logic [7:0]  rdata_q;
  logic        busy_q;
  logic [7:0]  rf_rdata;

  wire logic idle      = xs_q == SCA_X_IDLE;
  wire logic take      = lnk.wvalid && idle;
  wire logic frm_start = lnk.start && idle;
  wire logic frm_stop  = lnk.stop && idle;
  wire logic rd_req    = lnk.rreq && idle && is_rd_q;
  wire logic is_load   = cmd_q == SCA_MEM_HI;
  wire logic load_byte = take && is_wr_q && pos_q == 3'h4 && is_load
                         && cnt_q != 8'h00;
  wire logic acc_go    = cmd_q == SCA_CMD_ACC_HI && arg_q == SCA_CMD_ACC_LO
                         && lnk.wdata == SCA_CMD_DONE;
  wire logic cpc_go    = cmd_q == SCA_CMD_CPC && lnk.wdata == SCA_CMD_DONE;

  // operation described by the scratch memory
  wire logic [7:0]  x_dir  = mem_q[SCA_OFS_DIR];
  wire logic [7:0]  x_len  = mem_q[SCA_OFS_LEN];
  wire logic [15:0] x_base = {mem_q[SCA_OFS_AHI],
                              mem_q[SCA_OFS_ALO]};
  wire logic [7:0]  x_cnt  = (xs_q == SCA_X_CPC) ? mem_q[SCA_OFS_CPC_CNT]
                                                 : x_len;
  wire logic        x_more = idx_q != x_cnt;
  wire logic [6:0]  x_ofs  = data_ofs(idx_q);
  wire logic [15:0] rf_addr = x_base + {8'h00, idx_q};
  wire logic rf_we = xs_q == SCA_X_ACC && x_more && x_dir == SCA_DIR_WRITE;
  wire logic rf_rd = xs_q == SCA_X_ACC && x_more && x_dir == SCA_DIR_READ;

  sca_regfile u_sca_regfile (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .attach      (attach),
    .we          (rf_we),
    .addr        (rf_addr),
    .wdata       (mem_q[x_ofs]),
    .status_live (status_live),
    .rdata       (rf_rdata),
    .regs        (cfg_regs)
  );

  // frame parser
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_q      <= 3'h0;
      is_wr_q    <= 1'b0;
      is_rd_q    <= 1'b0;
      rd_first_q <= 1'b0;
      arm_acc_q  <= 1'b0;
      arm_cpc_q  <= 1'b0;
      cmd_q      <= 8'h00;
      arg_q      <= 8'h00;
      cnt_q      <= 8'h00;
      ptr_q      <= 7'h00;
    end else if (frm_start || frm_stop) begin
      // a stop drops any read still in progress
      pos_q     <= 3'h0;
      is_wr_q   <= 1'b0;
      is_rd_q   <= 1'b0;
      arm_acc_q <= 1'b0;
      arm_cpc_q <= 1'b0;
    end else if (take) begin
      if (pos_q != 3'h4) begin
        pos_q <= pos_q + 3'h1;
      end
      case (pos_q)
        3'h0: begin
          is_wr_q    <= lnk.wdata == SCA_ADDR_WR;
          is_rd_q    <= lnk.wdata == SCA_ADDR_RD;
          rd_first_q <= 1'b1;
        end
        3'h1: begin
          if (is_wr_q) begin
            cmd_q <= lnk.wdata;
          end
        end
        3'h2: begin
          if (is_wr_q) begin
            arg_q <= lnk.wdata;
            if (is_load) begin
              ptr_q <= lnk.wdata[6:0];
            end
            if (cpc_go) begin
              arm_cpc_q <= 1'b1;
            end
          end
        end
        3'h3: begin
          if (is_wr_q) begin
            if (is_load) begin
              cnt_q <= lnk.wdata;
            end
            if (acc_go) begin
              arm_acc_q <= 1'b1;
            end
          end
        end
        default: begin
          if (load_byte) begin
            ptr_q <= ptr_q + 7'h01;
            cnt_q <= cnt_q - 8'h01;
          end
        end
      endcase
    end else if (rd_req) begin
      rd_first_q <= 1'b0;
      if (!rd_first_q) begin
        ptr_q <= ptr_q + 7'h01;
      end
    end
  end

  // scratch memory: link loads and register read results
  always_ff @(posedge ref_clk) begin
    if (load_byte) begin
      mem_q[ptr_q] <= lnk.wdata;
    end else if (rf_rd) begin
      mem_q[x_ofs] <= rf_rdata;
    end
  end

  // read answers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
    end else begin
      rvalid_q <= lnk.rreq && idle;
      if (rd_req) begin
        rdata_q <= rd_first_q ? SCA_RD_COUNT : mem_q[ptr_q];
      end else if (lnk.rreq) begin
        rdata_q <= SCA_IDLE_BYTE;
      end
    end
  end

  // command execution, started at the stop of an armed frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      xs_q   <= SCA_X_IDLE;
      idx_q  <= 8'h00;
      busy_q <= 1'b0;
    end else begin
      case (xs_q)
        SCA_X_IDLE: begin
          idx_q <= 8'h00;
          if (frm_stop && arm_acc_q) begin
            xs_q   <= SCA_X_ACC;
            busy_q <= 1'b1;
          end else if (frm_stop && arm_cpc_q) begin
            xs_q   <= SCA_X_CPC;
            busy_q <= 1'b1;
          end
        end
        SCA_X_ACC, SCA_X_CPC: begin
          if (x_more) begin
            idx_q <= idx_q + 8'h01;
          end else begin
            xs_q   <= SCA_X_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          xs_q   <= SCA_X_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // charger port controller write strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpc_wr_valid <= 1'b0;
      cpc_wr_addr  <= 8'h00;
      cpc_wr_data  <= 8'h00;
    end else begin
      cpc_wr_valid <= xs_q == SCA_X_CPC && x_more;
      cpc_wr_addr  <= mem_q[SCA_OFS_CPC_ADDR] + idx_q;
      cpc_wr_data  <= mem_q[x_ofs];
    end
  end

  assign lnk.rvalid = rvalid_q;
  assign lnk.rdata  = rdata_q;
  assign lnk.busy   = busy_q;

endmodule // sca_device

/* File: design/sca_host.sv */
`timescale 1ns/1ps
module sca_host
  import sca_pkg::*;
(
  input  wire logic       ref_clk,    // core clock
  input  wire logic       rst,        // sync reset
  sca_link_if.host        lnk,        // link to the device
  input  wire logic       req_valid,  // start a transaction
  input  wire logic [1:0] req_kind,   // load, access, block write, read
  input  wire logic [6:0] req_offset, // scratch offset for load or read
  input  wire logic [7:0] req_len,    // payload byte count
  input  wire logic [7:0] data_in,    // payload byte at data_idx
  output logic            req_ready,  // idle, request accepted
  output logic      [7:0] data_idx,   // payload byte wanted next
  output logic            rd_valid,   // read byte valid
  output logic      [7:0] rd_data,    // read byte
  output logic            done        // transaction finished
);

  sca_hstate_e st_q;
  logic [1:0]  kind_q;
  logic [6:0]  off_q;
  logic [7:0]  len_q;
  logic [7:0]  idx_q;
  logic [7:0]  got_q;
  logic        pend_q;
  logic        start_q;
  logic        stop_q;
  logic        wvalid_q;
  logic [7:0]  wdata_q;
  logic        rreq_q;

  wire logic [7:0] total =
      (kind_q == SCA_K_LOAD) ? SCA_LOAD_HDR + len_q :
      (kind_q == SCA_K_ACC)  ? SCA_ACC_LEN :
      (kind_q == SCA_K_CPC)  ? SCA_CPC_LEN : SCA_SEL_LEN;
  wire logic [7:0] tail =
      (kind_q == SCA_K_ACC) ? SCA_CMD_ACC_LO : SCA_CMD_DONE;
  wire logic [7:0] cur_byte =
      (idx_q == 8'h00) ? SCA_ADDR_WR :
      (kind_q == SCA_K_ACC && idx_q == 8'h01) ? SCA_CMD_ACC_HI :
      (kind_q == SCA_K_CPC && idx_q == 8'h01) ? SCA_CMD_CPC :
      (kind_q == SCA_K_ACC && idx_q == 8'h03) ? SCA_CMD_DONE :
      (kind_q == SCA_K_ACC || kind_q == SCA_K_CPC) ? tail :
      (idx_q == 8'h01) ? SCA_MEM_HI :
      (idx_q == 8'h02) ? {1'b0, off_q} :
      (idx_q == 8'h03) ? len_q : data_in;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q      <= SCA_H_IDLE;
      kind_q    <= 2'h0;
      off_q     <= 7'h00;
      len_q     <= 8'h00;
      idx_q     <= 8'h00;
      got_q     <= 8'h00;
      pend_q    <= 1'b0;
      start_q   <= 1'b0;
      stop_q    <= 1'b0;
      wvalid_q  <= 1'b0;
      wdata_q   <= 8'h00;
      rreq_q    <= 1'b0;
      req_ready <= 1'b1;
      data_idx  <= 8'h00;
      rd_valid  <= 1'b0;
      rd_data   <= 8'h00;
      done      <= 1'b0;
    end else begin
      start_q  <= 1'b0;
      stop_q   <= 1'b0;
      wvalid_q <= 1'b0;
      rreq_q   <= 1'b0;
      rd_valid <= 1'b0;
      done     <= 1'b0;
      case (st_q)
        SCA_H_IDLE: begin
          if (req_valid && req_ready) begin
            kind_q    <= req_kind;
            off_q     <= req_offset;
            len_q     <= req_len;
            idx_q     <= 8'h00;
            data_idx  <= 8'h00;
            got_q     <= 8'h00;
            start_q   <= 1'b1;
            req_ready <= 1'b0;
            st_q      <= SCA_H_WRITE;
          end
        end
        SCA_H_WRITE: begin
          wvalid_q <= 1'b1;
          wdata_q  <= cur_byte;
          idx_q    <= idx_q + 8'h01;
          if (kind_q == SCA_K_LOAD && idx_q >= SCA_LOAD_HDR) begin
            data_idx <= data_idx + 8'h01;
          end
          if (idx_q + 8'h01 == total) begin
            st_q <= (kind_q == SCA_K_READ) ? SCA_H_RSTART : SCA_H_STOP;
          end
        end
        SCA_H_RSTART: begin
          start_q <= 1'b1;
          st_q    <= SCA_H_RADDR;
        end
        SCA_H_RADDR: begin
          wvalid_q <= 1'b1;
          wdata_q  <= SCA_ADDR_RD;
          st_q     <= SCA_H_READ;
        end
        SCA_H_READ: begin
          if (!pend_q) begin
            rreq_q <= 1'b1;
            pend_q <= 1'b1;
          end else if (lnk.rvalid) begin
            pend_q <= 1'b0;
            got_q  <= got_q + 8'h01;
            // first answer is the count byte, not data
            if (got_q != 8'h00) begin
              rd_valid <= 1'b1;
              rd_data  <= lnk.rdata;
            end
            if (got_q == len_q) begin
              st_q <= SCA_H_STOP;
            end
          end
        end
        SCA_H_STOP: begin
          stop_q <= 1'b1;
          pend_q <= 1'b1;
          st_q   <= SCA_H_WAIT;
        end
        SCA_H_WAIT: begin
          // skip one cycle so busy from the stop is visible
          pend_q <= 1'b0;
          if (!pend_q && !lnk.busy) begin
            done      <= 1'b1;
            req_ready <= 1'b1;
            st_q      <= SCA_H_IDLE;
          end
        end
        default: begin
          req_ready <= 1'b1;
          st_q      <= SCA_H_IDLE;
        end
      endcase
    end
  end

  assign lnk.start  = start_q;
  assign lnk.stop   = stop_q;
  assign lnk.wvalid = wvalid_q;
  assign lnk.wdata  = wdata_q;
  assign lnk.rreq   = rreq_q;

endmodule // sca_host

/* File: verification/sca_assertions.sv */
`timescale 1ns/1ps
module sca_assertions
  import sca_pkg::*;
(
  input wire logic       ref_clk, // shared clock
  input wire logic       rst,     // sync reset
  input wire logic       start,   // frame start
  input wire logic       stop,    // frame stop
  input wire logic       wvalid,  // master byte valid
  input wire logic [7:0] wdata,   // master byte
  input wire logic       rreq,    // read byte request
  input wire logic       rvalid,  // device byte valid
  input wire logic [7:0] rdata,   // device byte
  input wire logic       busy     // device executing
);
  logic       first_q;  // next master byte is the address byte
  logic       rdfr_q;   // inside a read frame
  logic       cnt_q;    // count byte still owed
  logic [8:0] busy_n_q; // cycles that busy has stood high
  wire        rd_addr = wvalid && first_q && wdata == SCA_ADDR_RD;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_q  <= 1'b0;
      rdfr_q   <= 1'b0;
      cnt_q    <= 1'b0;
      busy_n_q <= 9'h000;
    end else begin
      first_q  <= start || (first_q && !wvalid);
      rdfr_q   <= rd_addr || (rdfr_q && !stop && !start);
      cnt_q    <= rd_addr || (cnt_q && !rvalid && !stop);
      busy_n_q <= busy ? busy_n_q + 9'h001 : 9'h000;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_hdr;
    start ##1 (wvalid && wdata == SCA_ADDR_WR);
  endsequence
  sequence s_acc;
    s_hdr ##1 (wvalid && wdata == SCA_CMD_ACC_HI)
      ##1 (wvalid && wdata == SCA_CMD_ACC_LO)
      ##1 (wvalid && wdata == SCA_CMD_DONE) ##1 stop;
  endsequence
  sequence s_cpc;
    s_hdr ##1 (wvalid && wdata == SCA_CMD_CPC)
      ##1 (wvalid && wdata == SCA_CMD_DONE) ##1 stop;
  endsequence

  chk_access_runs: assert property (s_acc |=> busy)
    else $error("access frame did not start execution");
  chk_block_runs: assert property (s_cpc |=> busy)
    else $error("block write frame did not start execution");
  chk_busy_cause: assert property ($rose(busy) |-> $past(stop))
    else $error("busy rose without a frame stop");
  chk_busy_bound: assert property (busy_n_q <= 9'h100)
    else $error("busy held longer than the largest length");
  chk_read_answer: assert property (rreq && !busy |=> rvalid)
    else $error("read request not answered next cycle");
  chk_answer_cause: assert property (rvalid |-> $past(rreq))
    else $error("read byte without a request");
  property p_count_first;
    rvalid && cnt_q |-> rdata == SCA_RD_COUNT;
  endproperty
  chk_count_first: assert property (p_count_first)
    else $error("first read byte is not the count");
  chk_read_quiet: assert property (stop && rdfr_q |=> !busy [*2])
    else $error("ended read frame started execution");
endmodule // sca_assertions

/* File: verification/tb_smbus_config_register_access.sv */
`timescale 1ns/1ps
`define CHK(a, b) chk_val(16'(a), 16'(b))
module tb_smbus_config_register_access;
  import sca_pkg::*;
  logic                   ref_clk     = 1'b0;
  logic                   rst         = 1'b1;
  logic                   req_valid   = 1'b0;
  logic [1:0]             req_kind    = 2'h0;
  logic [6:0]             req_offset  = 7'h00;
  logic [7:0]             req_len     = 8'h00;
  logic                   attach      = 1'b0;
  logic [SCA_NSTAT*8-1:0] status_live = '0;
  logic [7:0]             data_in, data_idx, rd_data, cpc_wr_addr, cpc_wr_data;
  logic                   req_ready, rd_valid, done, cpc_wr_valid;
  logic [SCA_NREG*8-1:0]  cfg_regs;
  logic [7:0]             pay [256];
  logic [7:0]             sm [128];
  logic [7:0]             exp_r [SCA_NREG];
  logic [7:0]             exp_w [$], exp_l [$], exp_d [$];
  logic [15:0]            exp_c [$];
  logic [31:0]            seed = 32'h5229;
  int                     err_total = 0;
  int                     cmp_count = 0;

  always #2 ref_clk = ~ref_clk;
  assign data_in = pay[data_idx];

  sca_link_if u_sca_link_if (.ref_clk(ref_clk));
  sca_host u_sca_host (.ref_clk(ref_clk), .rst(rst), .lnk(u_sca_link_if),
    .req_valid(req_valid), .req_kind(req_kind), .req_offset(req_offset),
    .req_len(req_len), .data_in(data_in), .req_ready(req_ready),
    .data_idx(data_idx), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done));
  sca_device u_sca_device (.ref_clk(ref_clk), .rst(rst),
    .lnk(u_sca_link_if), .attach(attach), .status_live(status_live),
    .cfg_regs(cfg_regs), .cpc_wr_valid(cpc_wr_valid),
    .cpc_wr_addr(cpc_wr_addr), .cpc_wr_data(cpc_wr_data));
  sca_assertions u_sca_assertions (.ref_clk(ref_clk), .rst(rst),
    .start(u_sca_link_if.start), .stop(u_sca_link_if.stop),
    .wvalid(u_sca_link_if.wvalid), .wdata(u_sca_link_if.wdata),
    .rreq(u_sca_link_if.rreq), .rvalid(u_sca_link_if.rvalid),
    .rdata(u_sca_link_if.rdata), .busy(u_sca_link_if.busy));

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic setp(input logic [7:0] a, b, c, d);
    pay[0] = a;
    pay[1] = b;
    pay[2] = c;
    pay[3] = d;
  endtask

  task automatic run(input sca_kind_e k, input logic [6:0] o,
                     input logic [7:0] n);
    int t;
    req_kind   <= k;
    req_offset <= o;
    req_len    <= n;
    req_valid  <= 1'b1;
    @(posedge ref_clk);
    while (req_ready !== 1'b1) @(posedge ref_clk);
    req_valid <= 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      @(posedge ref_clk);
      t++;
    end
    if (t == 3000) err_total++;
  endtask

  task automatic load(input logic [6:0] o, input int n);
    exp_w.push_back(SCA_ADDR_WR);
    exp_w.push_back(SCA_MEM_HI);
    exp_w.push_back({1'b0, o});
    exp_w.push_back(8'(n));
    for (int i = 0; i < n; i++) begin
      exp_w.push_back(pay[i]);
      sm[7'(o + i)] = pay[i];
    end
    run(SCA_K_LOAD, o, 8'(n));
  endtask

  task automatic exec(input sca_kind_e k);
    exp_w.push_back(SCA_ADDR_WR);
    if (k == SCA_K_ACC) begin
      exp_w.push_back(SCA_CMD_ACC_HI);
      exp_w.push_back(SCA_CMD_ACC_LO);
    end else
      exp_w.push_back(SCA_CMD_CPC);
    exp_w.push_back(SCA_CMD_DONE);
    run(k, 7'h00, 8'h00);
  endtask

  task automatic rd(input logic [6:0] o, input int n);
    exp_w.push_back(SCA_ADDR_WR);
    exp_w.push_back(SCA_MEM_HI);
    exp_w.push_back({1'b0, o});
    exp_w.push_back(SCA_ADDR_RD);
    exp_l.push_back(SCA_RD_COUNT);
    for (int i = 0; i < n; i++) begin
      exp_l.push_back(sm[7'(o + i)]);
      exp_d.push_back(sm[7'(o + i)]);
    end
    run(SCA_K_READ, o, 8'(n));
  endtask

  task automatic check_all();
    logic [7:0] e;
    for (int i = 0; i < SCA_NREG; i++) begin
      if (SCA_REG_IS_STAT[i]) begin
        e = status_live[SCA_REG_SLOT[i]*8 +: 8];
        `CHK(cfg_regs[i*8 +: 8], e);
      end else
        `CHK(cfg_regs[i*8 +: 8], exp_r[i]);
    end
  endtask

  task automatic live();
    for (int i = 0; i < SCA_NSTAT; i++) status_live[i*8 +: 8] <= rnd();
    repeat (3) @(posedge ref_clk);
  endtask

  // result watcher: each result retires the oldest note of its kind
  always @(posedge ref_clk) begin
    if (u_sca_link_if.wvalid === 1'b1 && exp_w.size() > 0)
      `CHK(u_sca_link_if.wdata, exp_w.pop_front());
    if (u_sca_link_if.rvalid === 1'b1 && exp_l.size() > 0)
      `CHK(u_sca_link_if.rdata, exp_l.pop_front());
    if (rd_valid === 1'b1 && exp_d.size() > 0)
      `CHK(rd_data, exp_d.pop_front());
    if (cpc_wr_valid === 1'b1 && exp_c.size() > 0)
      `CHK({cpc_wr_addr, cpc_wr_data}, exp_c.pop_front());
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end

  initial begin
    exp_r = SCA_REG_INIT;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    live();
    check_all();
    for (int k = 0; k < 3; k++) begin
      setp(SCA_DIR_WRITE, 8'h04, 8'h08, 8'h06);
      for (int i = 0; i < 4; i++) begin
        pay[4+i] = rnd();
        exp_r[i] = pay[4+i];
      end
      load(7'h00, 8);
      exec(SCA_K_ACC);
      live();
      check_all();
      setp(SCA_DIR_READ, 8'h03, 8'h08, 8'h07);
      load(7'h00, 4);
      exec(SCA_K_ACC);
      for (int i = 0; i < 3; i++) sm[4+i] = exp_r[1+i];
      rd(7'h04, 3);
      rd(7'h01, 1);
      rd(7'h04, 0);
    end
    // write to an address outside the map must leave every register alone
    setp(SCA_DIR_WRITE, 8'h02, 8'h12, 8'h34);
    pay[4] = rnd();
    pay[5] = rnd();
    load(7'h00, 6);
    exec(SCA_K_ACC);
    check_all();
    // a direction byte other than write or read leaves every register alone
    setp(8'h02, 8'h01, 8'h08, 8'h06);
    pay[4] = rnd();
    load(7'h00, 5);
    exec(SCA_K_ACC);
    check_all();
    setp(SCA_DIR_WRITE, 8'h00, rnd(), 8'h03);
    for (int i = 0; i < 3; i++) begin
      pay[4+i] = rnd();
      exp_c.push_back({8'(pay[2] + i), pay[4+i]});
    end
    load(7'h00, 7);
    exec(SCA_K_CPC);
    attach <= 1'b1;
    @(posedge ref_clk);
    attach <= 1'b0;
    exp_r = SCA_REG_INIT;
    repeat (2) @(posedge ref_clk);
    check_all();
    repeat (4) @(posedge ref_clk);
    `CHK(exp_w.size() + exp_l.size(), 0);
    `CHK(exp_d.size() + exp_c.size(), 0);
    finish_test();
  end
endmodule // tb_smbus_config_register_access
